// ---- isvm_arbiter.sv ----
// Picks the highest ranked pending vector with a nonzero priority
`timescale 1ns/1ps
module isvm_arbiter (
    // Pending vectors and their priority slots
    input  wire logic [31:0]          vec_req_i,
    input  wire logic [31:0][4:0]     vec_field_i,
    // Winner
    output isvm_pkg::isvm_core_req_t  win_o
);

    logic [4:0] best;
    logic       found;

    // Walk down so that on a tie the lower vector is taken last and wins
    always_comb begin
        best  = 5'h00;
        found = 1'b0;
        win_o = '0;
        for (int v = isvm_pkg::ISVM_NUM_VEC - 1; v >= 0; v--) begin
            if (vec_req_i[v] && (vec_field_i[v][4:2] != 3'h0) &&
                (!found || vec_field_i[v] >= best)) begin
                found        = 1'b1;
                best         = vec_field_i[v];
                win_o.valid  = 1'b1;
                win_o.prio   = vec_field_i[v][4:2];
                win_o.sub    = vec_field_i[v][1:0];
                win_o.vector = 5'(v);
            end
        end
    end

endmodule

// ---- isvm_core_model.sv ----
// Model of the processor core that samples the vectored request
`timescale 1ns/1ps
module isvm_core_model (
    // Clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_i,
    // Request from the map, as latched by the core
    input  wire isvm_pkg::isvm_core_req_t  req_i,
    output isvm_pkg::isvm_core_req_t       taken_o
);
    // The core registers the request line once a cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            taken_o <= '0;
        end else begin
            taken_o <= req_i;
        end
    end
endmodule

// ---- isvm_pin_sync.sv ----
// Two-stage synchroniser for the external pin events
`timescale 1ns/1ps
module isvm_pin_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    // Pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule

// ---- isvm_pkg.sv ----
// Shared constants, source map and carrier types of the interrupt map
package isvm_pkg;

    // Source and vector counts
    localparam int ISVM_NUM_IRQ  = 39;
    localparam int ISVM_NUM_VEC  = 32;
    localparam int ISVM_NUM_PRIO = 8;
    localparam int ISVM_NUM_PIN  = 5;
    localparam int ISVM_HI_BASE  = 32;
    localparam int ISVM_HI_BITS  = 7;

    // Register byte offsets on the slave bus
    localparam logic [7:0] ISVM_OFF_FLAG0  = 8'h00;
    localparam logic [7:0] ISVM_OFF_FLAG1  = 8'h04;
    localparam logic [7:0] ISVM_OFF_EN0    = 8'h08;
    localparam logic [7:0] ISVM_OFF_EN1    = 8'h0c;
    localparam logic [7:0] ISVM_OFF_PRIO0  = 8'h10;
    localparam logic [7:0] ISVM_OFF_STRIDE = 8'h04;
    localparam logic [7:0] ISVM_OFF_STATUS = 8'h30;

    // Reset values and implemented-bit masks
    localparam logic [31:0] ISVM_RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] ISVM_HI_MASK   = 32'h0000_007f;
    localparam logic [31:0] ISVM_PRIO_MASK = 32'h1f1f_1f1f;

    // Field layout of one vector slot inside a priority register
    localparam int ISVM_SLOT_STRIDE = 8;
    localparam int ISVM_SLOT_BITS   = 5;
    localparam int ISVM_PRIO_LSB    = 2;
    localparam int ISVM_SLOTS       = 4;

    // Vector number of each source, source 38 first
    localparam logic [38:0][4:0] ISVM_IRQ_VECTOR = {
        5'h1f, 5'h1f, 5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h1a,
        5'h19, 5'h18, 5'h17, 5'h16, 5'h15, 5'h15, 5'h14, 5'h13,
        5'h12, 5'h11, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0d,
        5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h09, 5'h08, 5'h07, 5'h06,
        5'h05, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

    // Sources whose flag is set again on every cycle that the source level is high
    localparam logic [38:0] ISVM_PERSIST = 39'h78_1631_8c60;

    // Source numbers of the external pin events
    localparam int ISVM_PIN_IRQ [ISVM_NUM_PIN] = '{3, 8, 13, 18, 23};

    // Request handed to the core
    typedef struct packed {
        logic       valid;
        logic [2:0] prio;
        logic [1:0] sub;
        logic [4:0] vector;
    } isvm_core_req_t;

endpackage

// ---- isvm_top.sv ----
// Interrupt source to vector map with flag, enable and priority registers
`timescale 1ns/1ps
module isvm_top (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_i,
    // Avalon-MM slave
    input  wire logic [7:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // Event sources
    input  wire logic [38:0]          periph_event_i,
    input  wire logic [4:0]           pin_event_i,
    // Vectored request to the core
    output isvm_pkg::isvm_core_req_t  core_req_o
);

    logic [4:0]                pin_sync;
    logic [38:0]               src_now;
    logic [38:0]               src_prev_reg;
    logic [38:0]               set_vec;
    logic [38:0]               flag_reg;
    logic [38:0]               flag_next;
    logic [38:0]               enable_reg;
    logic [38:0]               enable_next;
    logic [38:0]               pend;
    logic [7:0][31:0]          prio_reg;
    logic [31:0]               vec_req;
    logic [31:0][4:0]          vec_fields;
    logic [31:0][4:0]          fields_q;
    logic [31:0]               rd_value;
    logic [31:0]               hi_merge;
    logic                      wr_fire;
    logic                      rd_take;
    isvm_pkg::isvm_core_req_t  arb_win;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Address match for a register offset
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        return addr == off;
    endfunction

    // True when exactly one source is pending
    function automatic logic solo(input logic [38:0] p, input int irq);
        return p == (39'h1 << irq);
    endfunction

    // Pin events cross into the clock domain first
    isvm_pin_sync #(
        .WIDTH    (isvm_pkg::ISVM_NUM_PIN)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i  (reset_i),
        .async_i  (pin_event_i),
        .sync_o   (pin_sync)
    );

    // Merge pin events into the source vector
    always_comb begin
        src_now = periph_event_i;
        for (int p = 0; p < isvm_pkg::ISVM_NUM_PIN; p++) begin
            src_now[isvm_pkg::ISVM_PIN_IRQ[p]] = pin_sync[p];
        end
    end

    // Previous source levels for edge detection
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            src_prev_reg <= '0;
        end else begin
            src_prev_reg <= src_now;
        end
    end

    // Persistent sources set while high, the rest on a rising edge
    assign set_vec = (src_now & isvm_pkg::ISVM_PERSIST) |
                     (src_now & ~src_prev_reg & ~isvm_pkg::ISVM_PERSIST);

    // Bus handshake: a request sees waitrequest low on its second edge
    assign rd_take = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    assign wr_fire = avs_write_i && !avs_waitrequest_o;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (rd_take) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        rd_value = isvm_pkg::ISVM_RST_WORD;
        if (hit(avs_address_i, isvm_pkg::ISVM_OFF_FLAG0)) begin
            rd_value = flag_reg[31:0];
        end else if (hit(avs_address_i, isvm_pkg::ISVM_OFF_FLAG1)) begin
            rd_value = {25'h0, flag_reg[38:32]};
        end else if (hit(avs_address_i, isvm_pkg::ISVM_OFF_EN0)) begin
            rd_value = enable_reg[31:0];
        end else if (hit(avs_address_i, isvm_pkg::ISVM_OFF_EN1)) begin
            rd_value = {25'h0, enable_reg[38:32]};
        end else if (hit(avs_address_i, isvm_pkg::ISVM_OFF_STATUS)) begin
            rd_value = {21'h0, core_req_o};
        end
        for (int i = 0; i < isvm_pkg::ISVM_NUM_PRIO; i++) begin
            if (hit(avs_address_i, 8'(isvm_pkg::ISVM_OFF_PRIO0 +
                    i * isvm_pkg::ISVM_OFF_STRIDE))) begin
                rd_value = prio_reg[i];
            end
        end
    end

    // Read data latched one edge before it is taken
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            avs_readdata_o <= isvm_pkg::ISVM_RST_WORD;
        end else if (rd_take && avs_read_i) begin
            avs_readdata_o <= rd_value;
        end
    end

    // Upper word write image, only seven bits exist
    assign hi_merge = be_merge({25'h0, flag_reg[38:32]}, avs_writedata_i,
                               avs_byteenable_i) & isvm_pkg::ISVM_HI_MASK;

    // Flag update: a hardware set wins over a software clear
    always_comb begin
        flag_next = flag_reg;
        if (wr_fire && hit(avs_address_i, isvm_pkg::ISVM_OFF_FLAG0)) begin
            flag_next[31:0] = be_merge(flag_reg[31:0], avs_writedata_i,
                                       avs_byteenable_i);
        end
        if (wr_fire && hit(avs_address_i, isvm_pkg::ISVM_OFF_FLAG1)) begin
            flag_next[38:32] = hi_merge[6:0];
        end
        flag_next = flag_next | set_vec;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Enable update
    always_comb begin
        enable_next = enable_reg;
        if (wr_fire && hit(avs_address_i, isvm_pkg::ISVM_OFF_EN0)) begin
            enable_next[31:0] = be_merge(enable_reg[31:0], avs_writedata_i,
                                         avs_byteenable_i);
        end
        if (wr_fire && hit(avs_address_i, isvm_pkg::ISVM_OFF_EN1)) begin
            enable_next[38:32] = 7'(be_merge({25'h0, enable_reg[38:32]},
                avs_writedata_i, avs_byteenable_i));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            enable_reg <= '0;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // Priority registers, reserved bits held at zero
    generate
        for (genvar g = 0; g < isvm_pkg::ISVM_NUM_PRIO; g++) begin : g_prio
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    prio_reg[g] <= isvm_pkg::ISVM_RST_WORD;
                end else if (wr_fire && hit(avs_address_i,
                        8'(isvm_pkg::ISVM_OFF_PRIO0 +
                        g * isvm_pkg::ISVM_OFF_STRIDE))) begin
                    prio_reg[g] <= be_merge(prio_reg[g], avs_writedata_i,
                        avs_byteenable_i) & isvm_pkg::ISVM_PRIO_MASK;
                end
            end
        end
    endgenerate

    // Slot of each vector: four per register, 8 bits apart
    always_comb begin
        for (int v = 0; v < isvm_pkg::ISVM_NUM_VEC; v++) begin
            vec_fields[v] = prio_reg[v / isvm_pkg::ISVM_SLOTS][
                isvm_pkg::ISVM_SLOT_STRIDE * (v % isvm_pkg::ISVM_SLOTS)
                +: isvm_pkg::ISVM_SLOT_BITS];
        end
    end

    // Pending sources fold onto their shared vectors
    assign pend = flag_reg & enable_reg;
    always_comb begin
        vec_req = '0;
        for (int i = 0; i < isvm_pkg::ISVM_NUM_IRQ; i++) begin
            if (pend[i]) begin
                vec_req[isvm_pkg::ISVM_IRQ_VECTOR[i]] = 1'b1;
            end
        end
    end

    // Rank vectors: priority, then sub-priority, then lowest number
    isvm_arbiter u_arbiter (
        .vec_req_i  (vec_req),
        .vec_field_i(vec_fields),
        .win_o      (arb_win)
    );

    // Registered request to the core
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            core_req_o <= '0;
            fields_q   <= '0;
        end else begin
            core_req_o <= arb_win;
            fields_q   <= vec_fields;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    // Upper flag word reads back sources 32 to 38
    a_flag_high_word: assert property (
        (avs_read_i && avs_waitrequest_o &&
         hit(avs_address_i, isvm_pkg::ISVM_OFF_FLAG1))
        |=> avs_readdata_o == {25'h0, $past(flag_reg[38:32])})
        else $error("upper flag word readback wrong");

    // Forwarded priority matches the winner's slot
    a_prio_slot_match: assert property (
        core_req_o.valid |->
        {core_req_o.prio, core_req_o.sub} == fields_q[core_req_o.vector])
        else $error("forwarded priority not from vector slot");

    // Capture event alone goes to the shared vector 5
    a_capture_shared: assert property (
        (solo(pend, 6) && vec_fields[5][4:2] != 3'h0)
        |=> core_req_o.valid && core_req_o.vector == 5'h05)
        else $error("capture event not on vector 5");

    // Serial receive alone goes to vector 31
    a_serial_shared: assert property (
        (solo(pend, 37) && vec_fields[31][4:2] != 3'h0)
        ##1 core_req_o.valid |-> core_req_o.vector == 5'h1f)
        else $error("serial receive not on vector 31");

    // Converter level keeps its flag set
    a_persist_refill: assert property (
        src_now[28] |=> flag_reg[28] && flag_reg[28] == $past(src_now[28]))
        else $error("persistent flag lost while source high");

    // Timer beats soft event 0 on equal rank
    a_timer_first: assert property (
        (pend == 39'h3 && vec_fields[0] == vec_fields[1] &&
         vec_fields[0][4:2] != 3'h0) |=> core_req_o.vector == 5'h00)
        else $error("core timer lost natural order");

    // Soft event 1 alone goes to vector 2
    a_soft_vector: assert property (
        (solo(pend, 2) && vec_fields[2][4:2] != 3'h0)
        |=> core_req_o.vector == 5'h02)
        else $error("soft event 1 not on vector 2");

    // Last pin event goes to vector 19
    a_pin_vector: assert property (
        (solo(pend, 23) && vec_fields[19][4:2] != 3'h0)
        |=> core_req_o.vector == 5'h13)
        else $error("pin event 4 not on vector 19");

    // Fifth compare source goes to vector 22
    a_compare_vector: assert property (
        (solo(pend, 27) && vec_fields[22][4:2] != 3'h0)
        |=> core_req_o.vector == 5'h16)
        else $error("compare 5 not on vector 22");

    // Clock monitor goes to vector 24
    a_monitor_vector: assert property (
        (solo(pend, 29) && vec_fields[24][4:2] != 3'h0)
        |=> core_req_o.vector == 5'h18)
        else $error("clock monitor not on vector 24");

    // Third comparator goes to vector 29
    a_comp_vector: assert property (
        (solo(pend, 34) && vec_fields[29][4:2] != 3'h0)
        |=> core_req_o.vector == 5'h1d)
        else $error("comparator 3 not on vector 29");

    // USB goes to vector 30 from slot bits 20:16 of register 7
    a_usb_vector: assert property (
        (solo(pend, 35) && prio_reg[7][20:18] != 3'h0)
        |=> core_req_o.vector == 5'h1e &&
            core_req_o.prio == $past(prio_reg[7][20:18]))
        else $error("USB not on vector 30");

    // Nothing pending means no request
    a_idle_silent: assert property (
        (pend == 39'h0) |=> !core_req_o.valid)
        else $error("request without pending source");

endmodule

// ---- isvm_top_tb.sv ----
// Self-checking bench for the interrupt source to vector map
`timescale 1ns/1ps
module isvm_top_tb;
    // Design drive and observation
    logic                     sys_clk_i;
    logic                     reset_i;
    logic [7:0]               avs_address_i;
    logic                     avs_read_i;
    logic                     avs_write_i;
    logic [31:0]              avs_writedata_i;
    logic [3:0]               avs_byteenable_i;
    logic [31:0]              avs_readdata_o;
    logic                     avs_waitrequest_o;
    logic [38:0]              periph_event_i;
    logic [4:0]               pin_event_i;
    isvm_pkg::isvm_core_req_t core_req_o;
    isvm_pkg::isvm_core_req_t taken;
    int                       err_total = 0;
    int                       checked = 0;
    int                       cycles = 0;
    logic [31:0]              rd;
    // Expected vector of each source, and the level-held sources
    localparam int VT [39] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 9, 10, 11,
        12, 13, 13, 14, 15, 16, 17, 17, 18, 19, 20, 21, 21, 22, 23, 24, 25,
        26, 27, 28, 29, 30, 31, 31, 31};
    localparam logic [38:0] PERSIST = 39'h78_1631_8c60;

    isvm_top dut_u (
        .sys_clk_i         (sys_clk_i),
        .reset_i           (reset_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .periph_event_i    (periph_event_i),
        .pin_event_i       (pin_event_i),
        .core_req_o        (core_req_o)
    );

    isvm_core_model core_u (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .req_i     (core_req_o),
        .taken_o   (taken)
    );

    // 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard: the whole run needs under 3000 cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One access, held until waitrequest is sampled low, then a gap
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        avs_address_i    <= a;
        avs_read_i       <= !w;
        avs_write_i      <= w;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, exp);
    endtask

    // Main sequence
    initial begin
        int          p;
        logic [7:0]  a;
        logic [31:0] b;
        reset_i          = 1'b1;
        avs_address_i    = 8'h00;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h0;
        avs_byteenable_i = 4'h0;
        periph_event_i   = '0;
        pin_event_i      = 5'h00;
        tick(2);
        reset_i <= 1'b0;
        tick(1);
        // Reset values, status and unmapped words read zero
        for (int k = 0; k < 17; k++) rchk(8'(4 * k), 32'h0);
        chk({21'h0, core_req_o}, 32'h0);
        $display("test reset done");

        // Implemented bits and byte lanes
        wr(8'h04, 32'hffff_ffff);
        rchk(8'h04, 32'h0000_007f);
        wr(8'h0c, 32'hffff_ffff);
        rchk(8'h0c, 32'h0000_007f);
        wr(8'h10, 32'hffff_ffff);
        rchk(8'h10, 32'h1f1f_1f1f);
        bus(1'b1, 8'h10, 32'h0, 4'h2);
        rchk(8'h10, 32'h1f1f_001f);
        wr(8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h0);
        wr(8'h04, 32'h0);
        $display("test registers done");

        // Every source: flag place, vector, persistence
        for (int k = 0; k < 8; k++) wr(8'h10 + 8'(4 * k), 32'h1d1d_1d1d);
        wr(8'h08, 32'hffff_ffff);
        wr(8'h0c, 32'h0000_007f);
        for (int n = 0; n < 39; n++) begin
            p = (n < 24 && n % 5 == 3) ? n / 5 : -1;
            a = (n < 32) ? 8'h00 : 8'h04;
            b = 32'h1 << (n % 32);
            if (p >= 0) pin_event_i[p] <= 1'b1;
            else periph_event_i[n] <= 1'b1;
            tick(6);
            chk({21'h0, taken}, {21'h0, 6'h3d, 5'(VT[n])});
            rchk(a, b);
            wr(a, 32'h0);
            tick(2);
            rchk(a, PERSIST[n] ? b : 32'h0);
            if (p >= 0) pin_event_i[p] <= 1'b0;
            else periph_event_i[n] <= 1'b0;
            tick(3);
            wr(a, 32'h0);
            tick(3);
            chk({31'h0, taken.valid}, 32'h0);
        end
        $display("test source map done");

        // Timer and soft event 0 pending together at equal rank
        periph_event_i[1:0] <= 2'h3;
        tick(4);
        chk({21'h0, taken}, 32'h0000_07a0);
        periph_event_i[1:0] <= 2'h0;
        wr(8'h00, 32'h0);

        // Ranking between two pending vectors
        periph_event_i[4]  <= 1'b1;
        periph_event_i[29] <= 1'b1;
        tick(4);
        chk({21'h0, taken}, 32'h0000_07a4);
        bus(1'b1, 8'h28, 32'h0000_001f, 4'h1);
        tick(3);
        rchk(isvm_pkg::ISVM_OFF_STATUS, 32'h0000_07f8);
        bus(1'b1, 8'h28, 32'h0000_001b, 4'h1);
        bus(1'b1, 8'h14, 32'h0000_001c, 4'h1);
        tick(3);
        chk({21'h0, taken}, 32'h0000_0784);
        bus(1'b1, 8'h28, 32'h0, 4'h1);
        bus(1'b1, 8'h14, 32'h0, 4'h1);
        tick(3);
        chk({31'h0, taken.valid}, 32'h0);
        periph_event_i <= '0;
        $display("test ranking done");
        conclude();
    end
endmodule
